// ===== sltc_pkg.sv
// Constants and types for the serial link transmit control block.
// Functional notes
// - Link control bit 0 powers down and resets link.
// - Enabled link sends K28.5 under sync request.
// - Sync mode 00 normal, 10 force sync, 11 data.
// - Bypass sends byte with two zero upper bits.
// - Invert bit flips all ten symbol bits.
// - Checksum mode 00 sums bytes, 01 sums fields.
// - Checksum mode 10 transmits a zero checksum.
// - Injection 00 at sample input, 01 encoder output.
// - Injection 10 puts bytes at scrambler input.
// - Alignment starts on the (delay+1)th boundary after sync release.
`default_nettype none
package sltc_pkg;
	localparam int ADDR_W = 16;
	localparam int IDX_W = 14;
	localparam logic [13:0] IDX_PWR = 14'h0571;
	localparam logic [13:0] IDX_CTL2 = 14'h0572;
	localparam logic [13:0] IDX_CTL3 = 14'h0573;
	localparam logic [13:0] IDX_CTL4 = 14'h0574;
	localparam logic [13:0] IDX_STAT = 14'h0575;
	localparam logic [7:0] RST_PWR = 8'h00;
	localparam logic [7:0] RST_CTL2 = 8'h00;
	localparam logic [7:0] RST_CTL3 = 8'h00;
	localparam logic [7:0] RST_CTL4 = 8'h00;
	localparam logic [7:0] PWR_WMASK = 8'h01;
	localparam logic [7:0] CTL2_WMASK = 8'hf7;
	localparam logic [7:0] CTL4_WMASK = 8'hf7;
	localparam int PWR_DOWN_BIT = 0;
	localparam int SYNC_MODE_LSB = 6;
	localparam int SYNC_INV_BIT = 5;
	localparam int BYPASS_BIT = 2;
	localparam int SYM_INV_BIT = 1;
	localparam int CK_MODE_LSB = 6;
	localparam int INJ_LSB = 4;
	localparam int DELAY_LSB = 4;
	localparam logic [1:0] SYNC_FORCE_CGS = 2'h2;
	localparam logic [1:0] SYNC_FORCE_DATA = 2'h3;
	localparam logic [1:0] CK_BYTES = 2'h0;
	localparam logic [1:0] CK_FIELDS = 2'h1;
	localparam logic [1:0] INJ_SAMPLE = 2'h0;
	localparam logic [1:0] INJ_ENC_OUT = 2'h1;
	localparam logic [1:0] INJ_SCRAMBLER = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] K28_5 = 8'hbc;
	localparam logic [7:0] K28_0 = 8'h1c;
	localparam int FIFO_DEPTH = 16;
	localparam int CFG_BYTES = 11;
	// A set bit marks the lowest bit of one configuration field.
	localparam logic [7:0] CFG_SPLIT [11] = '{8'h01, 8'h11, 8'h61, 8'h81, 8'h01, 8'h01,
		8'h01, 8'h41, 8'h21, 8'h21, 8'h81};
	// Six-bit and four-bit code tables, negative running disparity form.
	localparam logic [5:0] ENC6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19,
		6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23,
		6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e,
		6'h2e, 6'h1e, 6'h2b};
	localparam logic [3:0] ENC4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
	typedef enum logic [2:0] {ST_OFF, ST_SYNC, ST_WAIT, ST_ALIGN, ST_DATA} sltc_state_e;
endpackage
`default_nettype wire

// ===== serial_link_tx_control.sv
// Serial link transmit control: register slave, sync handling, FIFO and symbol encoder.
`timescale 1ns/1ps
`default_nettype none

module sltc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic flush,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} sltc_fifo_s;
	sltc_fifo_s q_r;
	sltc_fifo_s q_nxt;
	logic push;
	logic pop;

	// Pointers wrap freely, so only power-of-two depths are served.
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("sltc_fifo depth must be a power of two of at least 2");
	end

	// Full and empty come straight from the occupancy count.
	assign in_ready = q_r.cnt != (AW + 1)'(DEPTH);
	assign out_valid = q_r.cnt != '0;
	assign out_data = q_r.mem[q_r.rp];

	// Next state: store on push, advance on pop, drop all on flush.
	always_comb begin
		q_nxt = q_r;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			q_nxt.mem[q_r.wp] = in_data;
			q_nxt.wp = q_r.wp + 1'b1;
		end
		if (pop) begin
			q_nxt.rp = q_r.rp + 1'b1;
		end
		q_nxt.cnt = q_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
		if (flush) begin
			q_nxt.wp = '0;
			q_nxt.rp = '0;
			q_nxt.cnt = '0;
		end
	end

	// State register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end
endmodule

module serial_link_tx_control #(
	parameter int FIFO_DEPTH = sltc_pkg::FIFO_DEPTH
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus, write side.
	input wire logic [sltc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Register bus, read side.
	input wire logic [sltc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Link timing from the receiver and the multiframe counter.
	input wire logic sync_request_input,
	input wire logic local_multiframe_clock_edge,
	// Sample bytes in.
	input wire logic [7:0] smp_data,
	input wire logic smp_valid,
	output logic smp_ready,
	// Test data source.
	input wire logic test_en,
	input wire logic [9:0] test_data,
	// Link configuration table, byte 0 in the low bits.
	input wire logic [sltc_pkg::CFG_BYTES*8-1:0] cfg_table,
	// Symbols out and link status.
	output logic [9:0] sym_data,
	output logic sym_valid,
	input wire logic sym_ready,
	output logic link_clk_en,
	output logic [7:0] cksum
);
	import sltc_pkg::*;

	typedef struct packed {
		logic aw_full;
		logic [IDX_W-1:0] aw_idx;
		logic w_full;
		logic w_en;
		logic [7:0] w_byte;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [15:0] rdata;
		logic [1:0] rresp;
		logic [7:0] pwr;
		logic [7:0] ctl2;
		logic [7:0] ctl3;
		logic [7:0] ctl4;
		logic [1:0] sync_ff;
		sltc_state_e st;
		logic [3:0] local_multiframe_clock_cnt;
		logic rd;
		logic [9:0] sym;
		logic sym_valid;
		logic [7:0] cksum;
	} sltc_top_s;
	sltc_top_s q_r;
	sltc_top_s q_nxt;
	logic f_in_valid;
	logic f_in_ready;
	logic [7:0] f_in_data;
	logic f_out_valid;
	logic f_out_ready;
	logic [7:0] f_out_data;
	logic [IDX_W-1:0] ridx;
	logic [1:0] inj;
	logic inj_smp;
	logic req;
	logic load;
	logic send;
	logic bypass;
	logic [7:0] byte_in;
	logic k_in;
	logic [10:0] enc_w;
	logic [9:0] sym_w;

	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("FIFO_DEPTH must be a power of two of at least 2");
	end

	// Register decode shared by the read and write paths.
	function automatic logic reg_mapped(input logic [IDX_W-1:0] idx);
		return idx == IDX_PWR || idx == IDX_CTL2 || idx == IDX_CTL3 ||
			idx == IDX_CTL4 || idx == IDX_STAT;
	endfunction

	// Plain byte sum over the configuration table.
	function automatic logic [7:0] sum_bytes(input logic [CFG_BYTES*8-1:0] t);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < CFG_BYTES; i++) begin
			s = s + t[i*8 +: 8];
		end
		return s;
	endfunction

	// Sum of each field shifted down to bit 0.
	function automatic logic [7:0] sum_fields(input logic [CFG_BYTES*8-1:0] t);
		logic [7:0] s;
		logic [7:0] acc;
		s = 8'h00;
		acc = 8'h00;
		for (int i = 0; i < CFG_BYTES; i++) begin
			for (int b = 7; b >= 0; b--) begin
				acc = {acc[6:0], t[i*8+b]};
				if (CFG_SPLIT[i][b]) begin
					s = s + acc;
					acc = 8'h00;
				end
			end
		end
		return s;
	endfunction

	// Encoder with running disparity; control symbols are K28.y only.
	function automatic logic [10:0] enc_8b10b(input logic [7:0] d, input logic k,
		input logic rd);
		logic [5:0] c6;
		logic [3:0] c4;
		logic r6;
		logic a7;
		logic bal4;
		c6 = k ? 6'h0f : ENC6[d[4:0]];
		if (rd && ($countones(c6) != 3 || (!k && d[4:0] == 5'h07))) begin
			c6 = ~c6;
		end
		r6 = rd ^ ($countones(c6) != 3);
		c4 = ENC4[d[7:5]];
		a7 = d[7:5] == 3'h7 && (k || (!r6 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 ||
			d[4:0] == 5'h14)) || (r6 && (d[4:0] == 5'h0b || d[4:0] == 5'h0d ||
			d[4:0] == 5'h0e)));
		if (a7) begin
			c4 = 4'h7;
		end
		bal4 = $countones(c4) == 2;
		if (k && bal4 && d[7:5] != 3'h3) begin
			c4 = r6 ? c4 : ~c4;
		end else if (r6 && (!bal4 || d[7:5] == 3'h3)) begin
			c4 = ~c4;
		end
		return {r6 ^ !bal4, c6, c4};
	endfunction

	sltc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.flush(q_r.pwr[PWR_DOWN_BIT]),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data(f_in_data),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data)
	);

	// Outputs come from the state register; readies are combinational.
	assign s_axi_awready = !q_r.aw_full && !q_r.bvalid;
	assign s_axi_wready = !q_r.w_full && !q_r.bvalid;
	assign s_axi_bvalid = q_r.bvalid;
	assign s_axi_bresp = q_r.bresp;
	assign s_axi_arready = !q_r.rvalid;
	assign s_axi_rvalid = q_r.rvalid;
	assign s_axi_rresp = q_r.rresp;
	assign s_axi_rdata = {16'h0000, q_r.rdata};
	assign sym_data = q_r.sym;
	assign sym_valid = q_r.sym_valid;
	assign link_clk_en = !q_r.pwr[PWR_DOWN_BIT];
	assign cksum = q_r.cksum;

	// All next-state logic of the block.
	always_comb begin
		q_nxt = q_r;
		q_nxt.sync_ff = {q_r.sync_ff[0], sync_request_input};
		// Write address and data are taken in either order, then answered.
		if (s_axi_awvalid && !q_r.aw_full && !q_r.bvalid) begin
			q_nxt.aw_full = 1'b1;
			q_nxt.aw_idx = s_axi_awaddr[ADDR_W-1:2];
		end
		if (s_axi_wvalid && !q_r.w_full && !q_r.bvalid) begin
			q_nxt.w_full = 1'b1;
			q_nxt.w_en = s_axi_wstrb[0];
			q_nxt.w_byte = s_axi_wdata[7:0];
		end
		if (q_r.aw_full && q_r.w_full && !q_r.bvalid) begin
			q_nxt.aw_full = 1'b0;
			q_nxt.w_full = 1'b0;
			q_nxt.bvalid = 1'b1;
			q_nxt.bresp = reg_mapped(q_r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
			if (q_r.w_en) begin
				if (q_r.aw_idx == IDX_PWR) begin
					q_nxt.pwr = q_r.w_byte & PWR_WMASK;
				end else if (q_r.aw_idx == IDX_CTL2) begin
					q_nxt.ctl2 = q_r.w_byte & CTL2_WMASK;
				end else if (q_r.aw_idx == IDX_CTL3) begin
					q_nxt.ctl3 = q_r.w_byte;
				end else if (q_r.aw_idx == IDX_CTL4) begin
					q_nxt.ctl4 = q_r.w_byte & CTL4_WMASK;
				end
			end
		end else if (q_r.bvalid && s_axi_bready) begin
			q_nxt.bvalid = 1'b0;
		end
		// Reads answer one cycle after the address is taken.
		ridx = s_axi_araddr[ADDR_W-1:2];
		if (s_axi_arvalid && !q_r.rvalid) begin
			q_nxt.rvalid = 1'b1;
			q_nxt.rresp = reg_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
			if (ridx == IDX_PWR) begin
				q_nxt.rdata = {8'h00, q_r.pwr};
			end else if (ridx == IDX_CTL2) begin
				q_nxt.rdata = {8'h00, q_r.ctl2};
			end else if (ridx == IDX_CTL3) begin
				q_nxt.rdata = {8'h00, q_r.ctl3};
			end else if (ridx == IDX_CTL4) begin
				q_nxt.rdata = {8'h00, q_r.ctl4};
			end else if (ridx == IDX_STAT) begin
				q_nxt.rdata = {5'h00, q_r.st, q_r.cksum};
			end else begin
				q_nxt.rdata = 16'h0000;
			end
		end else if (q_r.rvalid && s_axi_rready) begin
			q_nxt.rvalid = 1'b0;
		end
		// Checksum follows the table every cycle; mode 11 also gives zero.
		case (q_r.ctl3[CK_MODE_LSB +: 2])
			CK_BYTES: q_nxt.cksum = sum_bytes(cfg_table);
			CK_FIELDS: q_nxt.cksum = sum_fields(cfg_table);
			default: q_nxt.cksum = 8'h00;
		endcase
		// The pin is low while the receiver asks for sync.
		req = !(q_r.sync_ff[1] ^ q_r.ctl2[SYNC_INV_BIT]);
		if (q_r.ctl2[SYNC_MODE_LSB +: 2] == SYNC_FORCE_CGS) begin
			req = 1'b1;
		end else if (q_r.ctl2[SYNC_MODE_LSB +: 2] == SYNC_FORCE_DATA) begin
			req = 1'b0;
		end
		// Test bytes at the sample input take the FIFO from the sample source.
		inj = q_r.ctl3[INJ_LSB +: 2];
		inj_smp = test_en && inj == INJ_SAMPLE;
		f_in_valid = inj_smp || smp_valid;
		f_in_data = inj_smp ? test_data[7:0] : smp_data;
		smp_ready = f_in_ready && !inj_smp;
		// Link sequencing and choice of the next symbol.
		load = !q_r.sym_valid || sym_ready;
		send = 1'b0;
		byte_in = K28_5;
		k_in = 1'b1;
		f_out_ready = 1'b0;
		case (q_r.st)
			ST_OFF: begin
				q_nxt.st = ST_SYNC;
			end
			ST_SYNC: begin
				send = 1'b1;
				if (!req) begin
					q_nxt.st = ST_WAIT;
					q_nxt.local_multiframe_clock_cnt = 4'h0;
				end
			end
			ST_WAIT: begin
				send = 1'b1;
				if (req) begin
					q_nxt.st = ST_SYNC;
				end else if (local_multiframe_clock_edge) begin
					if (q_r.local_multiframe_clock_cnt == q_r.ctl4[DELAY_LSB +: 4]) begin
						q_nxt.st = ST_ALIGN;
					end else begin
						q_nxt.local_multiframe_clock_cnt = q_r.local_multiframe_clock_cnt + 4'h1;
					end
				end
			end
			ST_ALIGN: begin
				send = 1'b1;
				byte_in = K28_0;
				if (req) begin
					q_nxt.st = ST_SYNC;
				end else if (local_multiframe_clock_edge) begin
					q_nxt.st = ST_DATA;
				end
			end
			ST_DATA: begin
				k_in = 1'b0;
				f_out_ready = load;
				send = f_out_valid || (test_en && inj == INJ_ENC_OUT);
				byte_in = (test_en && inj == INJ_SCRAMBLER) ? test_data[7:0] : f_out_data;
				if (req) begin
					q_nxt.st = ST_SYNC;
				end
			end
			default: begin
				q_nxt.st = ST_OFF;
			end
		endcase
		// Encode, optionally bypass, invert, then allow raw test words.
		bypass = q_r.ctl2[BYPASS_BIT];
		enc_w = enc_8b10b(byte_in, k_in, q_r.rd);
		sym_w = bypass ? {2'b00, byte_in} : enc_w[9:0];
		sym_w = sym_w ^ {10{q_r.ctl2[SYM_INV_BIT]}};
		if (q_r.st == ST_DATA && test_en && inj == INJ_ENC_OUT) begin
			sym_w = test_data;
		end
		if (load) begin
			q_nxt.sym_valid = send;
			if (send) begin
				q_nxt.sym = sym_w;
				q_nxt.rd = bypass ? q_r.rd : enc_w[10];
			end
		end
		// Power-down holds the link in reset whatever else happens.
		if (q_r.pwr[PWR_DOWN_BIT]) begin
			q_nxt.st = ST_OFF;
			q_nxt.sym_valid = 1'b0;
			q_nxt.rd = 1'b0;
			q_nxt.local_multiframe_clock_cnt = 4'h0;
			f_out_ready = 1'b0;
		end
	end

	// State register with documented reset values.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_r <= '0;
			q_r.pwr <= RST_PWR;
			q_r.ctl2 <= RST_CTL2;
			q_r.ctl3 <= RST_CTL3;
			q_r.ctl4 <= RST_CTL4;
		end else begin
			q_r <= q_nxt;
		end
	end
endmodule

`default_nettype wire

// ===== sltc_checker.sv
// Port checker for the serial link transmit control block.
`timescale 1ns/1ps
`default_nettype none
module sltc_checker
	import sltc_pkg::*;
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus.
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	// Symbol stream.
	input wire logic [9:0] sym_data,
	input wire logic sym_valid,
	input wire logic sym_ready,
	input wire logic link_clk_en
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A write answers two edges after both channels are taken, a read one edge after its address.
	// Both answers stand until taken.
	b_answer_a:
	assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
		##2 s_axi_bvalid) else $error("write answer missing");
	r_answer_a:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	bresp_hold_a:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	rdata_hold_a:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	// A pending answer blocks new requests of its own kind.
	write_block_a:
	assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write not blocked");
	read_block_a:
	assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read not blocked");
	// Addresses outside the register file answer with an error and zero data.
	unmapped_read_a:
	assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr[15:2] < IDX_PWR ||
		s_axi_araddr[15:2] > IDX_STAT) |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read answered");
	// A symbol that waits for the sink must not change, unless the link is shut.
	sym_hold_a:
	assert property (sym_valid && !sym_ready && link_clk_en |=>
		!link_clk_en || (sym_valid && $stable(sym_data))) else $error("symbol changed early");
	// From the second cycle of power-down the stream must be quiet.
	pwr_quiet_a:
	assert property (!link_clk_en [*2] |-> !sym_valid) else $error("symbols while down");
	// Main traffic seen.
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	cover property (sym_valid && !sym_ready);
endmodule
`default_nettype wire

// ===== sltc_rx_model.sv
// Receiver model: sync request pin, multiframe pulses and symbol sink.
`timescale 1ns/1ps
`default_nettype none
module sltc_rx_model (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Bench controls.
	input wire logic want_sync,
	input wire logic stall,
	// Link side.
	output logic sync_request_input,
	output logic local_multiframe_clock_edge,
	output logic sym_ready
);
	logic [2:0] cnt_r;
	// Free multiframe count; a fixed short frame keeps the boundary tests quick.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt_r <= 3'h0;
		else
			cnt_r <= cnt_r + 3'h1;
	end
	// Pin is low while the receiver asks for sync; a stalling sink is ready on every other cycle.
	assign local_multiframe_clock_edge = (cnt_r == 3'h7);
	assign sync_request_input = !want_sync;
	assign sym_ready = !stall || cnt_r[0];
endmodule
`default_nettype wire

// ===== test_serial_link_tx_control.sv
// Self-checking testbench for the serial link transmit control block.
`timescale 1ns/1ps
`default_nettype none
module test_serial_link_tx_control;
	import sltc_pkg::*;
	localparam logic [15:0] A_PWR = {IDX_PWR, 2'b00};
	localparam logic [15:0] A_C2 = {IDX_CTL2, 2'b00};
	localparam logic [15:0] A_C3 = {IDX_CTL3, 2'b00};
	localparam logic [15:0] A_C4 = {IDX_CTL4, 2'b00};
	localparam logic [15:0] A_ST = {IDX_STAT, 2'b00};
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic sync_request_input, local_multiframe_clock_edge, smp_valid, smp_ready, test_en;
	logic sym_valid, sym_ready, link_clk_en, want_sync, stall;
	logic [7:0] smp_data, cksum;
	logic [9:0] test_data, sym_data, v;
	logic [87:0] cfg_table;
	int fail_count = 0;
	int checked = 0;
	serial_link_tx_control dut (.*);
	sltc_rx_model rx (.*);
	// Free-running clock.
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// Closing verdict, shared by the sequence and the watchdog.
	task automatic print_verdict();
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One comparison; unknowns never match.
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (e !== g) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// Bus write: both channels offered together, each dropped when taken.
	// The answer is accepted one cycle after it shows, so it must stand while it waits.
	task automatic wr(input logic [15:0] a, input logic [7:0] dv);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, dv};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		repeat (50) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
			s_axi_bready <= s_axi_bvalid;
		end
		s_axi_bready <= 1'b0;
		chk("bvalid", 32'h1, 32'(s_axi_bvalid));
		chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
	endtask
	// Bus read; data and response land in d and r, taken a cycle after they show.
	task automatic rd(input logic [15:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		repeat (50) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
			s_axi_rready <= s_axi_rvalid;
		end
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	// Read and compare, and state read from the status register.
	task automatic rr(input string n, input logic [15:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, d);
	endtask
	task automatic st(input logic [2:0] e);
		repeat (2) @(posedge aclk);
		rd(A_ST);
		chk("state", 32'(e), 32'(d[10:8]));
	endtask
	// Take the next accepted symbol after n cycles.
	task automatic getsym(input int n);
		repeat (n) @(posedge aclk);
		repeat (50) begin
			@(posedge aclk);
			if (sym_valid && sym_ready) break;
		end
		v = sym_data;
	endtask
	task automatic sy(input logic [9:0] e);
		getsym(20);
		chk("sym", 32'(e), 32'(v));
	endtask
	// Wait for k multiframe boundaries.
	task automatic lm(input int k);
		repeat (k) begin
			@(posedge aclk);
			while (!local_multiframe_clock_edge) @(posedge aclk);
		end
	endtask
	// Expected checksum: whole bytes, or each field right-aligned.
	function automatic logic [7:0] ck(input bit fields);
		logic [7:0] s, f;
		s = 8'h0;
		for (int i = 0; i < CFG_BYTES; i++) begin
			f = 8'h0;
			for (int k = 7; k >= 0; k--) begin
				f = {f[6:0], cfg_table[8*i+k]};
				if (fields ? CFG_SPLIT[i][k] : k == 0) begin
					s = s + f;
					f = 8'h0;
				end
			end
		end
		return s;
	endfunction
	// Watchdog; the run needs a few hundred cycles.
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		print_verdict();
	end
	// Main sequence.
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		{smp_valid, test_en, stall} = '0;
		s_axi_wstrb = 4'h1;
		want_sync = 1'b1;
		smp_data = 8'h3c;
		test_data = 10'h2a5;
		for (int i = 0; i < CFG_BYTES; i++) cfg_table[8*i+:8] = 8'(8'h37 * i + 8'h5);
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rr("pwr", A_PWR, 32'h0);
		rr("ctl2", A_C2, 32'h0);
		rr("ctl3", A_C3, 32'h0);
		rr("ctl4", A_C4, 32'h0);
		rr("hole", 16'h15d8, 32'h0);
		chk("slverr", 32'(RESP_SLVERR), 32'(r));
		wr(A_C2, 8'hff);
		rr("ctl2", A_C2, 32'hf7);
		wr(A_C2, 8'h00);
		getsym(6);
		chk("k28_5", 32'h1, 32'(v === 10'h0fa || v === 10'h305));
		wr(A_C2, 8'h04);
		sy(10'h0bc);
		wr(A_C2, 8'h06);
		sy(10'h343);
		for (int m = 0; m < 4; m++) begin
			wr(A_C3, 8'(m << 6));
			repeat (3) @(posedge aclk);
			chk("cksum", 32'(m >= 2 ? 8'h0 : ck(m == 1)), 32'(cksum));
		end
		wr(A_C4, 8'hf0);
		wr(A_C2, 8'hc0);
		st(3'h2);
		want_sync <= 1'b0;
		wr(A_C2, 8'h80);
		st(3'h1);
		wr(A_C2, 8'h20);
		st(3'h1);
		wr(A_C2, 8'h00);
		st(3'h2);
		want_sync <= 1'b1;
		wr(A_C4, 8'h20);
		st(3'h1);
		lm(1);
		want_sync <= 1'b0;
		lm(2);
		st(3'h2);
		lm(1);
		st(3'h3);
		lm(1);
		st(3'h4);
		smp_valid <= 1'b1;
		wr(A_C2, 8'h04);
		sy(10'h03c);
		wr(A_C2, 8'h06);
		sy(10'h3c3);
		test_en <= 1'b1;
		wr(A_C3, 8'h20);
		sy(10'h35a);
		wr(A_C3, 8'h10);
		sy(10'h2a5);
		wr(A_C3, 8'h00);
		sy(10'h35a);
		chk("smp_ready", 32'h0, 32'(smp_ready));
		test_en <= 1'b0;
		wr(A_C3, 8'h30);
		stall <= 1'b1;
		repeat (60) @(posedge aclk);
		chk("full", 32'h0, 32'(smp_ready));
		smp_valid <= 1'b0;
		stall <= 1'b0;
		repeat (40) @(posedge aclk);
		chk("empty", 32'h0, 32'(sym_valid));
		wr(A_PWR, 8'h01);
		repeat (3) @(posedge aclk);
		chk("clk_en", 32'h0, 32'(link_clk_en));
		chk("sym_valid", 32'h0, 32'(sym_valid));
		st(3'h0);
		want_sync <= 1'b1;
		wr(A_PWR, 8'h00);
		st(3'h1);
		print_verdict();
	end
endmodule
bind serial_link_tx_control sltc_checker chk_i (.*);
`default_nettype wire
